/* inc/mpsd_pkg.sv */
/*
 package of constants for the multipurpose pin sequence delay block.
 assumes a 100 MHz clock and a simple byte register port driven by the
 serial interface logic of the device.
*/
// Contract
// RULE1: seven-bit power-on delay gates pin assertion
// RULE2: delay code counts one millisecond per step
// RULE3: power-good mode selects regulator by low nibble
// RULE4: codes zero to nine map regulators
// RULE5: code ten drives AND of all
// RULE6: separate power-off delay, zero means none
// RULE7: top bit ignored on write, reads zero
`default_nettype none
package mpsd_pkg;
   // ***************************************************
   // register map
   // ***************************************************
   localparam logic [7:0] MPSD_OFS_ON_DELAY = 8'h00;  // pin1_power_on_delay
   localparam logic [7:0] MPSD_OFS_OFF_DELAY = 8'h01; // pin1_power_off_delay
   localparam logic [7:0] MPSD_RST_ON_DELAY = 8'h00;  // reset of on delay
   localparam logic [7:0] MPSD_RST_OFF_DELAY = 8'h00; // reset of off delay
   localparam int MPSD_DELAY_MSB = 6;                 // top bit of the delay field
   localparam logic [7:0] MPSD_DELAY_MASK = 8'h7f;    // writable bits
   // ***************************************************
   // power-good selector codes
   // ***************************************************
   localparam int MPSD_NUM_RAILS = 10;                // six bucks, three ldos, ddr ref
   localparam logic [3:0] MPSD_SEL_AND_ALL = 4'ha;    // and of all rails
   // ***************************************************
   // timing
   // ***************************************************
   localparam int MPSD_CLK_MHZ = 100;                 // clock rate
   localparam int MPSD_STEP_US = 1000;                // one delay step, microseconds
   localparam int MPSD_STEP_CYCLES = MPSD_STEP_US * MPSD_CLK_MHZ;
endpackage
`default_nettype wire

/* src/mpsd_delay_timer.sv */
/*
 delay timer: counts whole millisecond steps after a start pulse and
 raises done once the programmed number of steps has passed.
 assumes the start pulse and code are on the same clock.
*/
`timescale 1ns/1ps
`default_nettype none
module mpsd_delay_timer #(
   parameter int STEP_CYCLES = mpsd_pkg::MPSD_STEP_CYCLES
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic start,
   input wire logic abort,
   input wire logic [6:0] code,
   output logic done
);
   import mpsd_pkg::*;
   // elaboration check: a step must last at least one clock cycle
   if (STEP_CYCLES < 1) begin
      $error("step must be at least one cycle");
   end
   logic [31:0] sub_ff;  // cycles within a step
   logic [6:0] steps_ff; // steps left
   logic run_ff;         // counting
   logic done_ff;        // delay elapsed
   // RULE2: millisecond step counting
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         sub_ff <= 32'h0;
         steps_ff <= 7'h0;
         run_ff <= 1'b0;
         done_ff <= 1'b0;
      end else if (abort) begin
         run_ff <= 1'b0;
         done_ff <= 1'b0;
      end else if (start) begin
         sub_ff <= 32'h0;
         steps_ff <= code;
         run_ff <= (code != 7'h0);
         done_ff <= (code == 7'h0);
      end else if (run_ff) begin
         if (sub_ff == 32'(STEP_CYCLES - 1)) begin
            sub_ff <= 32'h0;
            if (steps_ff == 7'h1) begin
               run_ff <= 1'b0;
               done_ff <= 1'b1;
            end
            steps_ff <= steps_ff - 7'h1;
         end else begin
            sub_ff <= sub_ff + 32'h1;
         end
      end
   end
   assign done = done_ff;
endmodule
`default_nettype wire

/* src/mpsd_pin_sequencer.sv */
/*
 multipurpose pin one sequencing: two delay registers, power-on and
 power-off delay timers, and power-good selection.
 assumes sequence start pulses and power-good levels come from pins.
*/
`timescale 1ns/1ps
`default_nettype none
module mpsd_pin_sequencer #(
   parameter int STEP_CYCLES = mpsd_pkg::MPSD_STEP_CYCLES
) (
   input wire logic clock,
   input wire logic rstn,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   input wire logic power_on_start,
   input wire logic power_off_start,
   input wire logic power_good_mode,
   input wire logic [mpsd_pkg::MPSD_NUM_RAILS-1:0] power_good_flag,
   output logic multipurpose_pin_one
);
   import mpsd_pkg::*;
   // ***************************************************
   // registers
   // ***************************************************
   logic [6:0] on_delay_ff;  // power-on delay field
   logic [6:0] off_delay_ff; // power-off delay field
   logic [7:0] rdata_ff;     // read data
   // RULE7: top bit dropped on write
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         on_delay_ff <= MPSD_RST_ON_DELAY[MPSD_DELAY_MSB:0];
         off_delay_ff <= MPSD_RST_OFF_DELAY[MPSD_DELAY_MSB:0];
      end else if (reg_wr) begin
         // unmapped addresses fall through and change nothing
         if (reg_addr == MPSD_OFS_ON_DELAY) begin
            // only the seven field bits are kept
            on_delay_ff <= reg_wdata[MPSD_DELAY_MSB:0];
         end else if (reg_addr == MPSD_OFS_OFF_DELAY) begin
            off_delay_ff <= reg_wdata[MPSD_DELAY_MSB:0];
         end
      end
   end
   // RULE7: top bit reads zero
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         rdata_ff <= 8'h00;
      end else if (reg_rd) begin
         // read data holds until the next read strobe
         if (reg_addr == MPSD_OFS_ON_DELAY) begin
            rdata_ff <= {1'b0, on_delay_ff};
         end else if (reg_addr == MPSD_OFS_OFF_DELAY) begin
            rdata_ff <= {1'b0, off_delay_ff};
         end else begin
            // unmapped reads return zero
            rdata_ff <= 8'h00;
         end
      end
   end
   assign reg_rdata = rdata_ff;
   // ***************************************************
   // pin input synchronisers
   // ***************************************************
   localparam int SW = MPSD_NUM_RAILS + 3; // rails plus three controls
   logic [SW-1:0] s1_ff, s2_ff, s3_ff, st_ff; // three stages and stable value
   // three-stage capture of the asynchronous pins
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         s1_ff <= '0;
         s2_ff <= '0;
         s3_ff <= '0;
         st_ff <= '0;
      end else begin
         s1_ff <= {power_good_mode, power_off_start, power_on_start, power_good_flag};
         s2_ff <= s1_ff;
         s3_ff <= s2_ff;
         // a bit changes only once stages two and three agree
         for (int i = 0; i < SW; i++) begin
            if (s2_ff[i] == s3_ff[i]) begin
               st_ff[i] <= s3_ff[i];
            end
         end
      end
   end
   logic [MPSD_NUM_RAILS-1:0] pg_sync; // stable power-good flags
   logic on_lvl, off_lvl, pg_mode;     // stable controls
   logic on_prev_ff, off_prev_ff;      // edge memory
   logic on_pulse, off_pulse;          // sequence start pulses
   assign pg_sync = st_ff[MPSD_NUM_RAILS-1:0];
   assign on_lvl = st_ff[MPSD_NUM_RAILS];
   assign off_lvl = st_ff[MPSD_NUM_RAILS+1];
   assign pg_mode = st_ff[MPSD_NUM_RAILS+2];
   // previous levels, reset to the idle low of the pins
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         on_prev_ff <= 1'b0;
         off_prev_ff <= 1'b0;
      end else begin
         on_prev_ff <= on_lvl;
         off_prev_ff <= off_lvl;
      end
   end
   // one-cycle pulses on rising sequence inputs
   assign on_pulse = on_lvl & ~on_prev_ff;
   assign off_pulse = off_lvl & ~off_prev_ff;
   // ***************************************************
   // delay timers
   // ***************************************************
   logic on_done, off_done; // delays elapsed
   // RULE1: power-on delay from sequence start
   // an off start aborts a pending on delay
   mpsd_delay_timer #(.STEP_CYCLES(STEP_CYCLES)) u_on (
      .clock(clock),
      .rstn(rstn),
      .start(on_pulse),
      .abort(off_pulse),
      .code(on_delay_ff),
      .done(on_done)
   );
   // RULE6: power-off delay from sequence start
   // an on start aborts a pending off delay
   mpsd_delay_timer #(.STEP_CYCLES(STEP_CYCLES)) u_off (
      .clock(clock),
      .rstn(rstn),
      .start(off_pulse),
      .abort(on_pulse),
      .code(off_delay_ff),
      .done(off_done)
   );
   // ***************************************************
   // power-good selection
   // ***************************************************
   function automatic logic pg_pick(input logic [3:0] sel,
                                    input logic [MPSD_NUM_RAILS-1:0] pg);
      // RULE5: code ten gives and of all
      if (sel == MPSD_SEL_AND_ALL) begin
         return &pg;
      // RULE4: codes zero to nine pick one rail
      end else if (sel < MPSD_SEL_AND_ALL) begin
         return pg[sel];
      end else begin
         return 1'b0;
      end
   endfunction
   logic pin_ff; // pin drive
   logic seq_on_ff; // pin asserted by sequence
   // sequence state: a finished off delay wins over on
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         seq_on_ff <= 1'b0;
      end else if (off_done) begin
         seq_on_ff <= 1'b0;
      end else if (on_done) begin
         seq_on_ff <= 1'b1;
      end
   end
   // RULE3: power-good mode uses low nibble
   always_ff @(posedge clock or negedge rstn) begin
      if (!rstn) begin
         pin_ff <= 1'b0;
      end else if (pg_mode) begin
         pin_ff <= pg_pick(on_delay_ff[3:0], pg_sync);
      end else begin
         // sequence level when not in power-good mode
         pin_ff <= seq_on_ff;
      end
   end
   assign multipurpose_pin_one = pin_ff;
   // ***************************************************
   // checks
   // ***************************************************
   // a nonzero on delay has just been started
   sequence on_start_seq;
      on_pulse && !off_pulse && on_delay_ff != 7'h00;
   endsequence
   // a nonzero off delay has just been started
   sequence off_start_seq;
      off_pulse && !on_pulse && off_delay_ff != 7'h00;
   endsequence
   // the on timer stays quiet for two cycles
   sequence on_quiet_seq;
      !on_done[*2];
   endsequence
   // the off timer stays quiet for two cycles
   sequence off_quiet_seq;
      !off_done[*2];
   endsequence
   // off delay has run out with the pin in sequence mode
   sequence off_end_seq;
      off_done && !pg_mode ##1 !pg_mode;
   endsequence
   // RULE7: reads never show the top bit
   chk_top_bit_zero: assert property (@(posedge clock) disable iff (!rstn) // RULE7
      $past(reg_rd) |-> !reg_rdata[7])
      else $error("top bit read nonzero");
   // RULE1: on delay write lands
   chk_write_stored: assert property (@(posedge clock) disable iff (!rstn) // RULE1
      reg_wr && reg_addr == MPSD_OFS_ON_DELAY |=>
      on_delay_ff == $past(reg_wdata[MPSD_DELAY_MSB:0]))
      else $error("on delay write lost");
   // RULE6: off delay write lands
   chk_off_stored: assert property (@(posedge clock) disable iff (!rstn) // RULE6
      reg_wr && reg_addr == MPSD_OFS_OFF_DELAY |=>
      off_delay_ff == $past(reg_wdata[MPSD_DELAY_MSB:0]))
      else $error("off delay write lost");
   // RULE2: zero on delay acts at once
   chk_zero_delay_on: assert property (@(posedge clock) disable iff (!rstn) // RULE2
      on_pulse && !off_pulse && on_delay_ff == 7'h00 |=> on_done)
      else $error("zero on delay not immediate");
   // RULE6: zero off delay acts at once
   chk_zero_delay_off: assert property (@(posedge clock) disable iff (!rstn) // RULE6
      off_pulse && !on_pulse && off_delay_ff == 7'h00 |=> off_done)
      else $error("zero off delay not immediate");
   // RULE5: code ten gives and of rails
   chk_and_all: assert property (@(posedge clock) disable iff (!rstn) // RULE5
      pg_mode && on_delay_ff[3:0] == MPSD_SEL_AND_ALL |=> pin_ff == &$past(pg_sync))
      else $error("and of rails wrong");
   // RULE4: lower codes pick one rail
   chk_rail_pick: assert property (@(posedge clock) disable iff (!rstn) // RULE4
      pg_mode && on_delay_ff[3:0] < MPSD_SEL_AND_ALL |=> pin_ff == $past(pg_sync[on_delay_ff[3:0]]))
      else $error("rail pick wrong");
   // RULE3: unused codes hold pin low
   chk_mode_nibble: assert property (@(posedge clock) disable iff (!rstn) // RULE3
      pg_mode && on_delay_ff[3:0] > MPSD_SEL_AND_ALL |=> !pin_ff)
      else $error("unused code drives pin");
   // RULE1: no on completion right after start
   chk_no_early_on: assert property (@(posedge clock) disable iff (!rstn) // RULE1
      on_start_seq |=> on_quiet_seq)
      else $error("on delay ended early");
   // RULE6: no off completion right after start
   chk_no_early_off: assert property (@(posedge clock) disable iff (!rstn) // RULE6
      off_start_seq |=> off_quiet_seq)
      else $error("off delay ended early");
   // RULE6: finished off delay lowers pin
   chk_off_lowers: assert property (@(posedge clock) disable iff (!rstn) // RULE6
      off_end_seq |=> !pin_ff)
      else $error("off sequence left pin high");
endmodule
`default_nettype wire

/* test/mpsd_host_model.sv */
/*
 host model: byte register writes and reads on the block's strobe port.
 assumes one clock shared with the block, inputs sampled on rising edges.
*/
`timescale 1ns/1ps
`default_nettype none
module mpsd_host_model (
   input wire logic clock,
   output var logic reg_wr,
   output var logic reg_rd,
   output var logic [7:0] reg_addr,
   output var logic [7:0] reg_wdata,
   input wire logic [7:0] reg_rdata
);
   // idle bus at time zero
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // one write strobe, then data line no longer shows the byte
   task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
      @(posedge clock);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge clock);
      reg_wr <= 1'b0;
      reg_wdata <= ~d;
   endtask
   // one read strobe, data taken once it has settled
   task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
      @(posedge clock);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge clock);
      reg_rd <= 1'b0;
      @(posedge clock);
      #1 d = reg_rdata;
   endtask
endmodule
`default_nettype wire

/* test/multipurpose_pin_sequence_delay_tb.sv */
/*
 testbench: register access, on and off delays, power-good selection.
 assumes a short delay step of 10 cycles set on the block.
*/
`timescale 1ns/1ps
`default_nettype none
module multipurpose_pin_sequence_delay_tb;
   import mpsd_pkg::*;
   localparam int STEP = 10; // shortened delay step
   logic clock, rstn, reg_wr, reg_rd, on_st, off_st, pg_mode, pin;
   logic [7:0] reg_addr, reg_wdata, reg_rdata, rd;
   logic [MPSD_NUM_RAILS-1:0] flags;
   int failures = 0, checks = 0, cyc = 0;
   // clock and timeout ceiling
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 6000) begin
         failures = failures + 1;
         stop_test();
      end
   end
   mpsd_host_model host_u (.clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata));
   mpsd_pin_sequencer #(.STEP_CYCLES(STEP)) dut_u (.clock(clock), .rstn(rstn),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
      .reg_rdata(reg_rdata), .power_on_start(on_st), .power_off_start(off_st),
      .power_good_mode(pg_mode), .power_good_flag(flags), .multipurpose_pin_one(pin));
   task automatic stop_test();
      $display("checks %0d failures %0d", checks, failures);
      if (failures == 0 && checks > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   task automatic check_reg(input string n, input logic [7:0] e, input logic [7:0] g);
      checks++;
      if (g !== e) begin
         failures++;
         $display("mismatch %s expected %h seen %h", n, e, g);
      end
   endtask
   task automatic check_pin(input string n, input logic e);
      checks++;
      if (pin !== e) begin
         failures++;
         $display("mismatch %s expected %b seen %b", n, e, pin);
      end
   endtask
   task automatic wait_cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   // expected pin in power-good mode
   function automatic logic pg_exp(input int c, input logic [9:0] f);
      if (c < 10) return f[c];
      if (c == 10) return &f;
      return 1'b0;
   endfunction
   initial begin
      rstn = 1'b0; on_st = 1'b0; off_st = 1'b0; pg_mode = 1'b0; flags = 10'h000;
      repeat (12) @(posedge clock);
      rstn <= 1'b1;
      // reset values, masking, unmapped address
      host_u.read_reg(MPSD_OFS_ON_DELAY, rd); check_reg("on rst", MPSD_RST_ON_DELAY, rd);
      host_u.read_reg(MPSD_OFS_OFF_DELAY, rd); check_reg("off rst", MPSD_RST_OFF_DELAY, rd);
      host_u.write_reg(MPSD_OFS_ON_DELAY, 8'hff);
      host_u.write_reg(MPSD_OFS_OFF_DELAY, 8'h80);
      host_u.write_reg(8'h07, 8'h55);
      host_u.read_reg(MPSD_OFS_ON_DELAY, rd); check_reg("on top", 8'h7f, rd);
      host_u.read_reg(MPSD_OFS_OFF_DELAY, rd); check_reg("off top", 8'h00, rd);
      host_u.read_reg(8'h07, rd); check_reg("unmapped", 8'h00, rd);
      // on delay of 3 steps, off delay of 2 steps
      host_u.write_reg(MPSD_OFS_ON_DELAY, 8'h03);
      host_u.write_reg(MPSD_OFS_OFF_DELAY, 8'h02);
      @(posedge clock) on_st <= 1'b1;
      wait_cyc(3 * STEP - 2); check_pin("on early", 1'b0);
      wait_cyc(12); check_pin("on late", 1'b1);
      @(posedge clock) off_st <= 1'b1;
      on_st <= 1'b0;
      wait_cyc(2 * STEP - 2); check_pin("off early", 1'b1);
      wait_cyc(12); check_pin("off late", 1'b0);
      // zero codes act at once
      host_u.write_reg(MPSD_OFS_ON_DELAY, 8'h00);
      @(posedge clock) on_st <= 1'b1;
      off_st <= 1'b0;
      wait_cyc(9); check_pin("on zero", 1'b1);
      host_u.write_reg(MPSD_OFS_OFF_DELAY, 8'h00);
      @(posedge clock) off_st <= 1'b1;
      wait_cyc(9); check_pin("off zero", 1'b0);
      // every selector code against three flag patterns
      @(posedge clock) pg_mode <= 1'b1;
      for (int c = 0; c < 16; c++) begin
         host_u.write_reg(MPSD_OFS_ON_DELAY, 8'(c) | 8'h70);
         for (int p = 0; p < 3; p++) begin
            @(posedge clock);
            flags <= (p == 0) ? 10'h3ff : (p == 1) ? 10'(1 << (c % 10)) : ~10'(1 << (c % 10));
            wait_cyc(10); check_pin("pg sel", pg_exp(c, flags));
         end
      end
      // an off start aborts a pending on delay
      @(posedge clock) pg_mode <= 1'b0;
      on_st <= 1'b0;
      off_st <= 1'b0;
      host_u.write_reg(MPSD_OFS_ON_DELAY, 8'h05);
      @(posedge clock) on_st <= 1'b1;
      wait_cyc(20); check_pin("on pending", 1'b0);
      @(posedge clock) off_st <= 1'b1;
      wait_cyc(60); check_pin("on aborted", 1'b0);
      stop_test();
   end
endmodule
`default_nettype wire
